// *** design/adc_mode_result_control.sv ***
// Converter mode sequencing, result alignment and channel decode
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Power-down input stops comparators and blocks starts; converter stays on
// - Mode bit3 low adds two-cycle calibration
// - Mode bit2 low powers down after conversion
// - Mode bits1:0 pick resolution; 11 unused
// - 8-bit value in upper eight, low zeros
// - 10-bit value in upper ten, low zeros
// - Channels 16-30 quads 5-9, 31 temperature
module adc_mode_result_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // Mode and control from fabric
  input wire logic [adc_ctrl_pkg::MODE_W-1:0] I_MODE,
  input wire logic I_COMPARATOR_POWERDOWN,
  input wire logic I_START,
  input wire logic [adc_ctrl_pkg::CHAN_W-1:0] I_CHANNEL,
  // Comparator decision bit from the analog side
  input wire logic I_COMPARE,
  // Status and result
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_CALIBRATING,
  output logic O_CONVERTER_ON,
  output logic O_COMPARATOR_ON,
  output logic O_MODE_ERROR,
  output logic [adc_ctrl_pkg::RESULT_W-1:0] O_RESULT,
  output logic [2:0] O_PAD_SELECT,
  output logic [3:0] O_QUAD,
  output logic O_QUAD_SEL,
  output logic O_TEMP_MON_SEL
);
  import adc_ctrl_pkg::*;

  // ************************************************
  // Functions
  // ************************************************

  // Steps of approximation for a resolution code
  function automatic logic [3:0] steps_for(input logic [1:0] res);
    logic [3:0] s;
    s = STEPS_12;
    case (res)
      RES_8: s = STEPS_8;
      RES_10: s = STEPS_10;
      default: s = STEPS_12;
    endcase
    return s;
  endfunction

  // Align a raw value and force unused low bits to zero
  function automatic logic [RESULT_W-1:0] align(input logic [1:0] res,
                                               input logic [RESULT_W-1:0] v);
    logic [RESULT_W-1:0] r;
    r = v;
    case (res)
      RES_8: r = {v[RESULT_W-1:4], 4'h0};
      RES_10: r = {v[RESULT_W-1:2], 2'h0};
      default: r = v;
    endcase
    return r;
  endfunction

  // ************************************************
  // Input synchronisers
  // ************************************************

  logic [MODE_W-1:0] mode_s1_q;
  logic [MODE_W-1:0] mode_q;
  logic [2:0] ctl_s1_q;
  logic [2:0] ctl_q;

  // Two flip-flops on the mode, power-down, start and compare inputs
  always_ff @(posedge I_MCLK)
  begin
    mode_s1_q <= I_MODE;
    mode_q <= mode_s1_q;
    ctl_s1_q <= {I_COMPARATOR_POWERDOWN, I_START, I_COMPARE};
    ctl_q <= ctl_s1_q;
  end

  mode_s mode;
  wire pd_sync = ctl_q[2];
  wire start_sync = ctl_q[1];
  wire cmp_sync = ctl_q[0];
  assign mode = mode_s'(mode_q);

  // Start edge detection on the synchronised level
  logic start_d1_q;
  always_ff @(posedge I_MCLK)
  begin
    if (!I_NRST) start_d1_q <= 1'b0;
    else start_d1_q <= start_sync;
  end
  wire start_pulse = start_sync & ~start_d1_q;

  // ************************************************
  // Conversion sequencer
  // ************************************************

  typedef enum logic [3:0]
  {
    ST_OFF = 4'h1,
    ST_IDLE = 4'h2,
    ST_CONV = 4'h4,
    ST_CAL = 4'h8
  } state_e;

  state_e state_q;
  state_e state_d;
  logic [3:0] step_q;
  logic [3:0] step_d;
  logic [1:0] cal_q;
  logic [1:0] cal_d;
  logic [RESULT_W-1:0] sar_q;
  logic [RESULT_W-1:0] sar_d;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] result_d;
  logic [1:0] res_q;
  logic [1:0] res_d;
  logic done_q;
  logic done_d;

  wire mode_bad = (mode.res == RES_BAD);
  wire can_start = start_pulse & ~mode_bad & ~pd_sync;
  wire conv_last = (step_q == 4'h1);
  wire [3:0] bitpos = 4'(RESULT_W) - step_q;

  // Next-state and datapath
  always_comb
  begin
    state_d = state_q;
    step_d = step_q;
    cal_d = cal_q;
    sar_d = sar_q;
    result_d = result_q;
    res_d = res_q;
    done_d = 1'b0;
    unique case (state_q)
      ST_OFF, ST_IDLE:
      begin
        if (can_start)
        begin
          state_d = ST_CONV;
          res_d = mode.res;
          step_d = steps_for(mode.res);
          sar_d = '0;
        end
      end
      ST_CONV:
      begin
        sar_d[bitpos] = cmp_sync;
        step_d = step_q - 4'h1;
        if (conv_last)
        begin
          done_d = 1'b1;
          result_d = align(res_q, sar_d);
          if (!mode.cal_off)
          begin
            state_d = ST_CAL;
            cal_d = CAL_CYCLES;
          end
          else
          begin
            state_d = mode.stay_on ? ST_IDLE : ST_OFF;
          end
        end
      end
      ST_CAL:
      begin
        cal_d = cal_q - 2'h1;
        if (cal_q == 2'h1)
        begin
          state_d = mode.stay_on ? ST_IDLE : ST_OFF;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge I_MCLK)
  begin
    if (!I_NRST)
    begin
      state_q <= ST_OFF;
      step_q <= '0;
      cal_q <= '0;
      sar_q <= '0;
      result_q <= '0;
      res_q <= RES_12;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      step_q <= step_d;
      cal_q <= cal_d;
      sar_q <= sar_d;
      result_q <= result_d;
      res_q <= res_d;
      done_q <= done_d;
    end
  end

  // ************************************************
  // Channel decode
  // ************************************************

  chan_sel_s chan_q;
  wire [4:0] chan_off = I_CHANNEL - CHAN_QUAD_FIRST;
  wire in_quads = (I_CHANNEL >= CHAN_QUAD_FIRST) && (I_CHANNEL <= CHAN_QUAD_LAST);
  wire [2:0] pad_idx = 3'(chan_off % 5'h3);
  wire [3:0] quad_num = QUAD_FIRST + 4'(chan_off / 5'h3);

  // Registered decode of the selected channel
  always_ff @(posedge I_MCLK)
  begin
    if (!I_NRST) chan_q <= '0;
    else
    begin
      chan_q.quad_sel <= in_quads;
      chan_q.temp_mon_sel <= (I_CHANNEL == CHAN_TEMP_MON);
      chan_q.quad <= in_quads ? quad_num : 4'h0;
      chan_q.pad <= !in_quads ? 3'h0 :
                    (pad_idx == 3'h0) ? PAD_VOLT :
                    (pad_idx == 3'h1) ? PAD_CURR : PAD_TEMP;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************

  assign O_BUSY = (state_q == ST_CONV) || (state_q == ST_CAL);
  assign O_CALIBRATING = (state_q == ST_CAL);
  assign O_CONVERTER_ON = (state_q != ST_OFF);
  assign O_COMPARATOR_ON = O_CONVERTER_ON & ~pd_sync;
  assign O_MODE_ERROR = mode_bad;
  assign O_DONE = done_q;
  assign O_RESULT = result_q;
  assign O_QUAD_SEL = chan_q.quad_sel;
  assign O_TEMP_MON_SEL = chan_q.temp_mon_sel;
  assign O_QUAD = chan_q.quad;
  assign O_PAD_SELECT = chan_q.pad;

  // ************************************************
  // Assertions
  // ************************************************
  // Pin level two flops back must already have the comparators off
  property p_pd_comparator;
    @(posedge I_MCLK) disable iff (!I_NRST) $past(I_COMPARATOR_POWERDOWN, 2) |-> !O_COMPARATOR_ON;
  endproperty
  a_pd_comparator: assert property (p_pd_comparator) else $error("comparator on in power-down");
  property p_cal_two;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (state_q == ST_CONV && conv_last && !mode.cal_off) |=> O_CALIBRATING [*2] ##1 !O_CALIBRATING;
  endproperty
  a_cal_two: assert property (p_cal_two) else $error("calibration length wrong");
  property p_no_cal;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (state_q == ST_CONV && conv_last && mode.cal_off) |=> !O_CALIBRATING;
  endproperty
  a_no_cal: assert property (p_no_cal) else $error("calibration without request");
  // Power decision uses the mode seen in the last busy cycle
  property p_power_off;
    @(posedge I_MCLK) disable iff (!I_NRST)
      ($fell(O_BUSY) && !$past(mode.stay_on)) |-> !O_CONVERTER_ON;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converter left on");
  property p_bad_mode;
    @(posedge I_MCLK) disable iff (!I_NRST) (mode_bad && !O_BUSY) |=> !O_BUSY;
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("unused mode started");
  property p_res8;
    @(posedge I_MCLK) disable iff (!I_NRST) (O_DONE && res_q == RES_8) |-> O_RESULT[3:0] == 4'h0;
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit low bits not zero");
  property p_res10;
    @(posedge I_MCLK) disable iff (!I_NRST) (O_DONE && res_q == RES_10) |-> O_RESULT[1:0] == 2'h0;
  endproperty
  a_res10: assert property (p_res10) else $error("10-bit low bits not zero");
  property p_temp;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (I_CHANNEL == CHAN_TEMP_MON) |=> O_TEMP_MON_SEL && !O_QUAD_SEL;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature monitor not selected");
  property p_res12;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (state_q == ST_CONV && conv_last && res_q == RES_12) |=> O_RESULT == $past(sar_d);
  endproperty
  a_res12: assert property (p_res12) else $error("12-bit result altered");
endmodule
`default_nettype wire

// *** design/adc_ctrl_pkg.sv ***
// Package with mode fields, resolution codes, channel map and timing counts
package adc_ctrl_pkg;

  // Mode field layout
  localparam int MODE_W = 4;
  localparam int MODE_CAL_OFF_BIT = 3;
  localparam int MODE_STAY_ON_BIT = 2;
  localparam int RES_W = 2;

  // Resolution codes
  localparam logic [1:0] RES_10 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [1:0] RES_BAD = 2'h3;

  // Result word width and per-resolution step counts
  localparam int RESULT_W = 12;
  localparam logic [3:0] STEPS_8 = 4'h8;
  localparam logic [3:0] STEPS_10 = 4'ha;
  localparam logic [3:0] STEPS_12 = 4'hc;
  localparam logic [1:0] CAL_CYCLES = 2'h2;

  // Channel map
  localparam int CHAN_W = 5;
  localparam logic [4:0] CHAN_QUAD_FIRST = 5'h10;
  localparam logic [4:0] CHAN_QUAD_LAST = 5'h1e;
  localparam logic [4:0] CHAN_TEMP_MON = 5'h1f;
  localparam logic [3:0] QUAD_FIRST = 4'h5;

  // Pad kind selected by a channel
  typedef enum logic [2:0]
  {
    PAD_VOLT = 3'h1,
    PAD_CURR = 3'h2,
    PAD_TEMP = 3'h4
  } pad_kind_e;

  // Mode control carried as one bundle
  typedef struct packed
  {
    logic cal_off;
    logic stay_on;
    logic [1:0] res;
  } mode_s;

  // Channel decode result
  typedef struct packed
  {
    logic quad_sel;
    logic temp_mon_sel;
    logic [3:0] quad;
    logic [2:0] pad;
  } chan_sel_s;

endpackage

// *** tb/fabric_compare_source.sv ***
// Behavioural comparator decision source standing in for the analog side
`timescale 1ns/100ps
`default_nettype none
module fabric_compare_source
(
  // Clock
  input wire logic i_mclk,
  // Control from the bench
  input wire logic i_armed,
  input wire logic i_level,
  // Decision bit to the converter
  output logic o_compare
);
  // Hold the level while armed; toggle when idle so stale bits never look valid
  always_ff @(posedge i_mclk)
  begin
    o_compare <= i_armed ? i_level : (o_compare !== 1'b1);
  end
endmodule
`default_nettype wire

// *** tb/adc_mode_result_control_test.sv ***
// Self-checking bench for mode sequencing, result alignment and channel decode
`timescale 1ns/100ps
`default_nettype none
module adc_mode_result_control_test;
  import adc_ctrl_pkg::*;
  // ****************
  // Signals
  // ****************
  logic mclk, nrst, pdown, start, armed, level, cmp;
  logic busy, done, cal, conv_on, comp_on, mode_err, qsel, tsel;
  logic [MODE_W-1:0] mode;
  logic [CHAN_W-1:0] chan;
  logic [RESULT_W-1:0] result;
  logic [2:0] pad;
  logic [3:0] quad;
  logic [31:0] seed;
  int n_errors = 0;
  int n_compared = 0;
  // Clock at 100 MHz
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  adc_mode_result_control adc_mode_result_control_i (.I_MCLK(mclk), .I_NRST(nrst),
    .I_MODE(mode), .I_COMPARATOR_POWERDOWN(pdown), .I_START(start), .I_CHANNEL(chan),
    .I_COMPARE(cmp), .O_BUSY(busy), .O_DONE(done), .O_CALIBRATING(cal),
    .O_CONVERTER_ON(conv_on), .O_COMPARATOR_ON(comp_on), .O_MODE_ERROR(mode_err),
    .O_RESULT(result), .O_PAD_SELECT(pad), .O_QUAD(quad), .O_QUAD_SEL(qsel),
    .O_TEMP_MON_SEL(tsel));
  fabric_compare_source fabric_compare_source_i (.i_mclk(mclk), .i_armed(armed),
    .i_level(level), .o_compare(cmp));
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Left-aligned result when every decision bit equals the level
  function automatic logic [11:0] exp_result(input logic [1:0] res, input logic lvl);
    logic [11:0] m;
    m = (res == 2'h2) ? 12'hff0 : (res == 2'h0) ? 12'hffc : 12'hfff;
    return lvl ? m : 12'h000;
  endfunction
  // Decode as {quad select, monitor select, quad, pad}
  function automatic logic [8:0] exp_chan(input int c);
    if (c >= 16 && c <= 30)
      return {2'h2, 4'(5 + (c - 16) / 3), 3'(1 << ((c - 16) % 3))};
    return (c == 31) ? 9'h080 : 9'h000;
  endfunction
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One conversion with a constant decision level, timed at the ports
  task automatic convert(input logic [3:0] m, input logic lvl);
    int n;
    int k;
    @(posedge mclk);
    mode <= m;
    armed <= 1'b1;
    level <= lvl;
    repeat (3) @(posedge mclk);
    start <= 1'b1;
    n = 0;
    k = 0;
    @(negedge mclk);
    while (busy !== 1'b1 && k < 20)
    begin
      @(negedge mclk);
      k++;
    end
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    check("steps", (m[1:0] == 2'h2) ? 12'd8 : (m[1:0] == 2'h0) ? 12'd10 : 12'd12, 12'(n));
    check("result", exp_result(m[1:0], lvl), result);
    check("mode_error clear", 12'h0, {11'h0, mode_err});
    n = 0;
    k = 0;
    // First calibration cycle already stands at the done sample
    while (busy === 1'b1 && k < 10)
    begin
      n += int'(cal === 1'b1);
      @(negedge mclk);
      k++;
    end
    check("calibration", m[3] ? 12'd0 : 12'd2, 12'(n));
    check("converter_on", {11'h0, m[2]}, {11'h0, conv_on});
    @(posedge mclk);
    start <= 1'b0;
    armed <= 1'b0;
  endtask
  // Start attempt that must be ignored
  task automatic refused_start();
    @(posedge mclk);
    start <= 1'b1;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check("refused busy", 12'h0, {11'h0, busy});
    @(posedge mclk);
    start <= 1'b0;
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    mode = 4'h4;
    pdown = 1'b0;
    start = 1'b0;
    armed = 1'b0;
    level = 1'b0;
    chan = 5'h00;
    nrst = 1'b0;
    seed = 32'hf08b;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // Every mode combination, then again with random levels
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      convert({1'((i / 3) % 2), 1'((i / 6) % 2), 2'(i % 3)}, (i < 12) ? i[0] : seed[0]);
    end
    // Unused resolution code
    @(posedge mclk);
    mode <= 4'h7;
    repeat (3) @(posedge mclk);
    check("mode_error", 12'h1, {11'h0, mode_err});
    refused_start();
    // Comparator power-down leaves the converter powered
    convert(4'hd, seed[1]);
    pdown <= 1'b1;
    repeat (3) @(posedge mclk);
    check("comparator_on", 12'h0, {11'h0, comp_on});
    check("converter_on held", 12'h1, {11'h0, conv_on});
    refused_start();
    pdown <= 1'b0;
    // Channel decode over all numbers
    for (int c = 0; c < 32; c++)
    begin
      @(posedge mclk);
      chan <= 5'(c);
      @(posedge mclk);
      @(negedge mclk);
      check("channel", {3'h0, exp_chan(c)}, {3'h0, qsel, tsel, quad, pad});
    end
    summarize();
  end
  // Watchdog
  initial
  begin
    #100000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
